// ---- hw/ewp_cycle.sv ----
`timescale 1ns/100ps
// one write-strobe controlled byte cycle on the pins
module ewp_cycle (
  input wire logic clock_i,
  input wire logic rst_i,
  ewp_cyc_if.seq cyc,
  output logic chip_sel_n_o,
  output logic wr_strobe_n_o,
  output logic [14:0] addr_o,
  output logic [7:0] data_o,
  output logic data_oe_o
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_LOW, S_HOLD} ewp_cyc_type;
  ewp_cyc_type state;
  logic [3:0] cnt;

  // sequencer, strobe low only for full width so it is never a glitch
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      cnt <= 4'h0;
      chip_sel_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      addr_o <= 15'h0000;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      cyc.done <= 1'b0;
    end
    else
    begin
      cyc.done <= 1'b0;
      case (state)
        S_IDLE:
          if (cyc.start)
          begin
            addr_o <= cyc.addr;
            data_o <= cyc.data;
            data_oe_o <= 1'b1;
            chip_sel_n_o <= 1'b0;
            cnt <= 4'(ewp_pkg::SETUP_CYC);
            state <= S_SETUP;
          end
        S_SETUP:
          begin
            wr_strobe_n_o <= 1'b0;
            cnt <= 4'(ewp_pkg::STROBE_CYC);
            state <= S_LOW;
          end
        S_LOW:
          if (cnt <= 4'h1)
          begin
            wr_strobe_n_o <= 1'b1;
            state <= S_HOLD;
          end
          else
            cnt <= cnt - 4'h1;
        S_HOLD:
          begin
            chip_sel_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            cyc.done <= 1'b1;
            state <= S_IDLE;
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // ewp_cycle

// ---- hw/ewp_host.sv ----
`timescale 1ns/100ps
module ewp_host #(
  parameter int HOLD_CYCLES = ewp_pkg::HOLD_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic chip_sel_n_o,
  output logic out_gate_n_o,
  output logic wr_strobe_n_o,
  output logic protect_hold_n_o,
  output logic [14:0] addr_o,
  output logic [7:0] data_o,
  output logic data_oe_o
);
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_WAIT} ewp_host_type;
  ewp_host_type state;
  ewp_cyc_if cyc ();
  logic hold_en;
  logic [1:0] mode;
  logic [14:0] tgt_addr;
  logic [7:0] tgt_data;
  logic [2:0] step;
  logic [2:0] last_step;
  logic [31:0] hold_cnt;
  logic lock_state;
  logic started;
  logic [14:0] seq_addr;
  logic [7:0] seq_data;
  logic busy;
  logic [31:0] next_rdata;

  // readout gate is never used here, kept high for write-only path
  assign out_gate_n_o = 1'b1;
  assign busy = (state != H_IDLE);
  // registers answer in the same cycle, no waits
  assign avs_waitrequest_o = 1'b0;

  // control register, hold released only by software
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_en <= 1'b0;
      mode <= ewp_pkg::MODE_PLAIN;
      tgt_addr <= 15'h0000;
    end
    else if (avs_write_i && avs_address_i == ewp_pkg::REG_CTRL)
    begin
      hold_en <= avs_writedata_i[ewp_pkg::CTRL_HOLD_BIT];
      mode <= avs_writedata_i[ewp_pkg::CTRL_MODE_LO +: 2];
      tgt_addr <= avs_writedata_i[ewp_pkg::CTRL_ADDR_LO +: 15];
    end
  end

  // protect input follows the enable, kept high through the hold wait
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      protect_hold_n_o <= 1'b0;
    else
      protect_hold_n_o <= hold_en || (state == H_WAIT);
  end

  // code word for each step of the chosen sequence
  always_comb
  begin
    seq_addr = ewp_pkg::ADDR_A;
    seq_data = ewp_pkg::DAT_AA;
    last_step = 3'h0;
    case (mode)
      ewp_pkg::MODE_PLAIN:
        last_step = 3'h0;
      ewp_pkg::MODE_LOCKED, ewp_pkg::MODE_ARM:
        last_step = 3'h3;
      default:
        last_step = 3'h5;
    endcase
    case (step)
      3'h1:
      begin
        seq_addr = ewp_pkg::ADDR_B;
        seq_data = ewp_pkg::DAT_55;
      end
      3'h2:
        seq_data = (mode == ewp_pkg::MODE_DISARM) ? ewp_pkg::DAT_80
                                                  : ewp_pkg::DAT_A0;
      3'h4:
      begin
        seq_addr = ewp_pkg::ADDR_B;
        seq_data = ewp_pkg::DAT_55;
      end
      3'h5:
        seq_data = ewp_pkg::DAT_20;
      default:
        seq_data = ewp_pkg::DAT_AA;
    endcase
    // final step of unlock is the user byte itself
    if (mode != ewp_pkg::MODE_DISARM && step == last_step)
    begin
      seq_addr = tgt_addr;
      seq_data = tgt_data;
    end
  end

  // byte cycle request
  always_comb
  begin
    cyc.start = (state == H_RUN) && !started;
    cyc.addr = seq_addr;
    cyc.data = seq_data;
  end

  // sequence walker; a write to data starts it only with hold high
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= H_IDLE;
      step <= 3'h0;
      started <= 1'b0;
      tgt_data <= 8'h00;
      hold_cnt <= 32'h0;
      lock_state <= 1'b0;
    end
    else
    begin
      case (state)
        H_IDLE:
          if (avs_write_i && avs_address_i == ewp_pkg::REG_DATA &&
              protect_hold_n_o)
          begin
            tgt_data <= avs_writedata_i[7:0];
            step <= 3'h0;
            started <= 1'b0;
            state <= H_RUN;
          end
        H_RUN:
          if (!protect_hold_n_o)
            state <= H_IDLE;
          else if (cyc.done)
          begin
            started <= 1'b0;
            if (step == last_step)
            begin
              hold_cnt <= HOLD_CYCLES;
              state <= H_WAIT;
              if (mode == ewp_pkg::MODE_ARM)
                lock_state <= 1'b1;
              else if (mode == ewp_pkg::MODE_DISARM)
                lock_state <= 1'b0;
            end
            else
              step <= step + 3'h1;
          end
          else
            started <= 1'b1;
        H_WAIT:
          // keep protect high while the array programs
          if (hold_cnt <= 32'h1)
            state <= H_IDLE;
          else
            hold_cnt <= hold_cnt - 32'h1;
        default:
          state <= H_IDLE;
      endcase
    end
  end

  // status and register readback
  always_comb
  begin
    next_rdata = 32'h0;
    case (avs_address_i)
      ewp_pkg::REG_CTRL:
      begin
        next_rdata[ewp_pkg::CTRL_HOLD_BIT] = hold_en;
        next_rdata[ewp_pkg::CTRL_MODE_LO +: 2] = mode;
        next_rdata[ewp_pkg::CTRL_ADDR_LO +: 15] = tgt_addr;
      end
      ewp_pkg::REG_DATA:
        next_rdata[7:0] = tgt_data;
      ewp_pkg::REG_STAT:
      begin
        next_rdata[ewp_pkg::STAT_BUSY_BIT] = busy;
        next_rdata[ewp_pkg::STAT_HOLD_BIT] = protect_hold_n_o;
        next_rdata[ewp_pkg::STAT_WAIT_BIT] = (state == H_WAIT);
        next_rdata[ewp_pkg::STAT_LOCK_BIT] = lock_state;
      end
      default:
        next_rdata = 32'h0;
    endcase
  end
  assign avs_readdata_o = avs_read_i ? next_rdata : 32'h0;

  ewp_cycle u_cycle (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .cyc(cyc.seq),
    .chip_sel_n_o(chip_sel_n_o),
    .wr_strobe_n_o(wr_strobe_n_o),
    .addr_o(addr_o),
    .data_o(data_o),
    .data_oe_o(data_oe_o)
  );
endmodule // ewp_host

// ---- inc/ewp_cyc_if.sv ----
`timescale 1ns/100ps
interface ewp_cyc_if;
  logic start;
  logic [14:0] addr;
  logic [7:0] data;
  logic done;
  modport seq (input start, input addr, input data, output done);
  modport ctl (output start, output addr, output data, input done);
endinterface

// ---- inc/ewp_pkg.sv ----
package ewp_pkg;
  // clock rate and timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 50;
  // pulse width of write strobe, must stay well over noise limit
  localparam int NOISE_NS = 20;
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // setup before strobe
  localparam int SETUP_NS = 70;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // hold of protect input after last byte
  localparam int HOLD_MS = 10;
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  // unlock and disarm codes
  localparam logic [14:0] ADDR_A = 15'h5555;
  localparam logic [14:0] ADDR_B = 15'h2AAA;
  localparam logic [7:0] DAT_AA = 8'hAA;
  localparam logic [7:0] DAT_55 = 8'h55;
  localparam logic [7:0] DAT_A0 = 8'hA0;
  localparam logic [7:0] DAT_80 = 8'h80;
  localparam logic [7:0] DAT_20 = 8'h20;
  // avalon register map (byte offsets)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  // control fields
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_ADDR_LO = 8;
  // command modes
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_LOCKED = 2'h1;
  localparam logic [1:0] MODE_ARM = 2'h2;
  localparam logic [1:0] MODE_DISARM = 2'h3;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_WAIT_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
endpackage

// ---- sim/ewp_dev_model.sv ----
`timescale 1ns/100ps
// byte-wide eeprom with noise filter and software lock
module ewp_dev_model (
  input wire logic chip_sel_n_i,
  input wire logic out_gate_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic protect_hold_n_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] data_i,
  output logic locked_o,
  output int prog_cnt_o,
  output logic [22:0] prog_o
);
  wire logic strb_n = chip_sel_n_i | wr_strobe_n_i | !out_gate_n_i;
  logic [14:0] lat_a;
  logic [22:0] k;
  realtime t_fall;
  int st;
  // lock starts cleared
  initial
  begin
    locked_o = 1'b0;
    prog_cnt_o = 0;
    prog_o = '0;
    st = 0;
  end
  // address on leading edge
  always @(negedge strb_n)
  begin
    lat_a = addr_i;
    t_fall = $realtime;
  end
  // protect loss drops any partial code
  always @(negedge protect_hold_n_i) st = 0;
  // data on trailing edge, short pulses and protect low ignored
  always @(posedge strb_n)
    if (protect_hold_n_i && $realtime - t_fall > 20.0)
    begin
      k = {lat_a, data_i};
      case (st)
        0: st = (k == 23'h5555AA) ? 1 : 8;
        1: st = (k == 23'h2AAA55) ? 2 : 0;
        2: st = (k == 23'h5555A0) ? 3 : (k == 23'h555580) ? 4 : 0;
        3: st = 7;
        4: st = (k == 23'h5555AA) ? 5 : 0;
        5: st = (k == 23'h2AAA55) ? 6 : 0;
        6:
        begin
          if (k == 23'h555520) locked_o = 1'b0;
          st = 0;
        end
        default: st = 0;
      endcase
      // plain byte only when unlocked, code byte always
      if (st == 7 || (st == 8 && !locked_o))
      begin
        prog_o = k;
        prog_cnt_o++;
      end
      if (st == 7) locked_o = 1'b1;
      if (st >= 7) st = 0;
    end
endmodule // ewp_dev_model

// ---- sim/ewp_host_properties.sv ----
`timescale 1ns/100ps
// pin timing checks on the host controller
module ewp_host_properties #(
  parameter int HOLD_CYCLES = ewp_pkg::HOLD_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic chip_sel_n_o,
  input wire logic out_gate_n_o,
  input wire logic wr_strobe_n_o,
  input wire logic protect_hold_n_o,
  input wire logic [14:0] addr_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic strobe_q;
  logic [31:0] since_load;

  // cycles since the last write strobe ended, saturating
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strobe_q <= 1'b1;
      since_load <= 32'(HOLD_CYCLES);
    end
    else
    begin
      strobe_q <= wr_strobe_n_o;
      if (wr_strobe_n_o && !strobe_q)
        since_load <= 32'h0;
      else if (since_load < 32'(HOLD_CYCLES))
        since_load <= since_load + 32'h1;
    end
  end
  // strobes far wider than noise
  chk_strobe_width: assert property (
    $fell(wr_strobe_n_o) |-> !wr_strobe_n_o [*4] ##1 wr_strobe_n_o)
    else $error("write strobe width wrong");
  chk_select_width: assert property (
    $fell(chip_sel_n_o) |-> !chip_sel_n_o [*6] ##1 chip_sel_n_o)
    else $error("chip select width wrong");
  chk_gate_high: assert property (out_gate_n_o)
    else $error("output gate driven low");
  chk_strobe_in_select: assert property (
    !wr_strobe_n_o |-> !chip_sel_n_o && data_oe_o)
    else $error("strobe outside select");
  chk_protect_reset: assert property (
    $fell(rst_i) |-> !protect_hold_n_o)
    else $error("protect not low out of reset");
  chk_protect_fall: assert property (
    $fell(protect_hold_n_o) |-> since_load >= 32'(HOLD_CYCLES))
    else $error("protect dropped too soon after last byte");
  chk_protect_rise: assert property (
    $rose(protect_hold_n_o) |->
      $past(avs_write_i, 2) && $past(avs_address_i, 2) == ewp_pkg::REG_CTRL)
    else $error("protect raised without control write");
  chk_setup_cycle: assert property (
    $fell(chip_sel_n_o) |=> $fell(wr_strobe_n_o))
    else $error("no setup cycle before strobe");
  chk_addr_stable: assert property (
    $fell(chip_sel_n_o) |=> ($stable(addr_o) && $stable(data_o)) [*5])
    else $error("address or data moved in cycle");
endmodule // ewp_host_properties

bind ewp_host ewp_host_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .clock_i, .rst_i, .avs_address_i, .avs_write_i, .chip_sel_n_o,
  .out_gate_n_o, .wr_strobe_n_o, .protect_hold_n_o, .addr_o, .data_o,
  .data_oe_o);

// ---- sim/ewp_host_tb.sv ----
`timescale 1ns/100ps
module ewp_host_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rdat;
  logic avs_waitrequest_o, chip_sel_n_o, out_gate_n_o, wr_strobe_n_o;
  logic protect_hold_n_o, data_oe_o, locked;
  logic [14:0] addr_o;
  logic [7:0] data_o;
  logic [22:0] prog;
  int pcnt, fail_count = 0, samples_checked = 0;
  // 20 MHz clock
  always #25 clock_i = !clock_i;
  ewp_host #(.HOLD_CYCLES(20)) i_dut (.clock_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .chip_sel_n_o, .out_gate_n_o, .wr_strobe_n_o,
    .protect_hold_n_o, .addr_o, .data_o, .data_oe_o);
  ewp_dev_model i_dev (.chip_sel_n_i(chip_sel_n_o),
    .out_gate_n_i(out_gate_n_o), .wr_strobe_n_i(wr_strobe_n_o),
    .protect_hold_n_i(protect_hold_n_o), .addr_i(addr_o), .data_i(data_o),
    .locked_o(locked), .prog_cnt_o(pcnt), .prog_o(prog));
  task automatic final_report;
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  task automatic guard(input int n);
    if (n >= 100)
    begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // one avalon access, idle edge first
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0 && n < 100)
    begin
      @(posedge clock_i);
      n++;
    end
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    guard(n);
  endtask
  // poll status until neither busy nor waiting
  task automatic settle;
    int n;
    n = 0;
    do
    begin
      acc(1'b0, 4'h8, 32'h0);
      n++;
    end
    while ((rdat[0] !== 1'b0 || rdat[2] !== 1'b0) && n < 100);
    guard(n);
  endtask
  // control, data, then poll until idle
  task automatic op(input logic [1:0] m, input logic [14:0] a,
    input logic [7:0] d);
    acc(1'b1, 4'h0, {9'h0, a, 5'h0, m, 1'b1});
    acc(1'b1, 4'h4, {24'h0, d});
    settle();
  endtask
  // device state and lock status bit
  task automatic dev(input int c, input logic l, input logic [22:0] p);
    acc(1'b0, 4'h8, 32'h0);
    chk("stat_lock", {31'h0, l}, {31'h0, rdat[3]});
    chk("dev_lock", {31'h0, l}, {31'h0, locked});
    chk("dev_count", c, pcnt);
    chk("dev_byte", {9'h0, p}, {9'h0, prog});
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    chk("prot_reset", 32'h0, {31'h0, protect_hold_n_o});
    chk("cs_idle", 32'h1, {31'h0, chip_sel_n_o});
    acc(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rdat);
    dev(0, 1'b0, 23'h0);
    op(2'h0, 15'h0123, 8'h5A);
    dev(1, 1'b0, 23'h01235A);
    op(2'h2, 15'h0456, 8'h3C);
    dev(2, 1'b1, 23'h04563C);
    op(2'h1, 15'h0777, 8'hC3);
    dev(3, 1'b1, 23'h0777C3);
    op(2'h0, 15'h0100, 8'h11);
    dev(3, 1'b1, 23'h0777C3);
    op(2'h3, 15'h0, 8'h0);
    dev(3, 1'b0, 23'h0777C3);
    acc(1'b1, 4'h0, 32'h00030001);
    acc(1'b1, 4'h4, 32'h77);
    repeat (5) acc(1'b0, 4'h8, 32'h0);
    chk("hold_wait", 32'h7, {29'h0, rdat[2:0]});
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b0, 4'h8, 32'h0);
    chk("hold_kept", 32'h7, {29'h0, rdat[2:0]});
    settle();
    acc(1'b0, 4'h8, 32'h0);
    chk("hold_drop", 32'h0, {28'h0, rdat[3:0]});
    acc(1'b1, 4'h0, 32'h00000001);
    acc(1'b1, 4'h4, 32'h44);
    acc(1'b1, 4'h0, 32'h0);
    settle();
    chk("abort", 32'h0, {28'h0, rdat[3:0]});
    acc(1'b1, 4'h4, 32'h99);
    acc(1'b0, 4'h8, 32'h0);
    chk("refused", 32'h0, {31'h0, rdat[0]});
    dev(4, 1'b0, 23'h030077);
    final_report();
  end
endmodule // ewp_host_tb
